// [design/pdcw_consts.svh]
// Constants of the divider configuration word block
// Functional notes
// - Bits 1:0 of each serial word select its register; code 00 is this word.
// - Host shifts exactly 32 bits MSB first with latch low; latch rise transfers it.
// - Reference pre-divider is bits 11:2, reset value with seven low bits set.
// - Feedback divider is bits 23:12, reset value with seven low bits set.
// - Reference phase delay is bits 26:24, reset zero.
// - Feedback phase delay is bits 29:27, reset zero.
// - Bit 30 selects reference choice: 0 manual, 1 automatic; reset manual.
// - Bit 31 disables reference frequency detection when 1; reset enabled.
// - Detection enabled: reference status normal, low when reference under about 2 MHz.
// - Detection disabled: reference status held high regardless of reference clock.
`ifndef PDCW_CONSTS_SVH
`define PDCW_CONSTS_SVH

// ----------------------------------------
// Word layout
// ----------------------------------------
`define PDCW_WORD_W        32
`define PDCW_CNT_W         6
`define PDCW_CNT_FULL      6'h20
`define PDCW_CNT_OVER      6'h21
`define PDCW_SEL_LSB       0
`define PDCW_SEL_W         2
`define PDCW_SEL_THIS      2'h0
`define PDCW_PREDIV_LSB    2
`define PDCW_PREDIV_W      10
`define PDCW_PREDIV_RST    10'h07F
`define PDCW_FBDIV_LSB     12
`define PDCW_FBDIV_W       12
`define PDCW_FBDIV_RST     12'h07F
`define PDCW_REFDLY_LSB    24
`define PDCW_FBDLY_LSB     27
`define PDCW_DLY_W         3
`define PDCW_DLY_RST       3'h0
`define PDCW_AUTO_BIT      30
`define PDCW_AUTO_RST      1'h0
`define PDCW_DETDIS_BIT    31
`define PDCW_DETDIS_RST    1'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define PDCW_CLK_PERIOD_NS      10
`define PDCW_REF_MIN_FREQ_KHZ   2000
`define PDCW_REF_MAX_PERIOD_NS  (1000000 / `PDCW_REF_MIN_FREQ_KHZ)
`define PDCW_REF_TIMEOUT_CYC    (`PDCW_REF_MAX_PERIOD_NS / `PDCW_CLK_PERIOD_NS)
`define PDCW_REF_CNT_W          8
`define PDCW_FB_DIV_MAX_MHZ     250

`endif

// [design/pdcw_pkg.sv]
// Types of the divider configuration word block
`default_nettype none
package pdcw_pkg;

  typedef enum logic [2:0] {
    PDCW_ST_IDLE  = 3'h1,
    PDCW_ST_FRAME = 3'h2,
    PDCW_ST_LOAD  = 3'h4
  } pdcw_state_t;

  typedef struct packed {
    logic       detect_disable;
    logic       select_auto;
    logic [2:0] fb_delay;
    logic [2:0] ref_delay;
    logic [11:0] fb_div;
    logic [9:0] ref_prediv;
  } pdcw_cfg_t;

endpackage
`default_nettype wire

// [design/pdcw_link_if.sv]
// Carrier between the serial shifter and the core
`timescale 1ns/1ps
`default_nettype none
interface pdcw_link_if;
  logic [31:0] shift_word;
  logic [5:0]  bit_cnt;

  modport shifter (output shift_word, output bit_cnt);
  modport core    (input shift_word, input bit_cnt);
endinterface
`default_nettype wire

// [design/pdcw_shifter.sv]
// Serial link shifter on the link clock
`timescale 1ns/1ps
`default_nettype none
`include "pdcw_consts.svh"
module pdcw_shifter (
  // Link pins
  input  wire logic  ser_clk,
  input  wire logic  serial_latch_enable,
  input  wire logic  ser_data,
  // To core
  pdcw_link_if.shifter lnk
);

  logic                    armed_r;
  logic                    armed_nxt;
  logic [`PDCW_WORD_W-1:0] shift_r;
  logic [`PDCW_WORD_W-1:0] shift_nxt;
  logic [`PDCW_CNT_W-1:0]  cnt_r;
  logic [`PDCW_CNT_W-1:0]  cnt_nxt;

  // ----------------------------------------
  // Next values
  // ----------------------------------------
  always_comb begin
    armed_nxt = 1'b0;
    shift_nxt = {shift_r[`PDCW_WORD_W-2:0], ser_data};
    if (armed_r) begin
      cnt_nxt = 6'h01;
    end else if (cnt_r == `PDCW_CNT_OVER) begin
      cnt_nxt = cnt_r;
    end else begin
      cnt_nxt = cnt_r + 6'h01;
    end
  end

  // ----------------------------------------
  // Frame start flag, armed by the latch
  // ----------------------------------------
  always_ff @(posedge ser_clk or posedge serial_latch_enable) begin
    if (serial_latch_enable) begin
      armed_r <= 1'b1;
    end else begin
      armed_r <= armed_nxt;
    end
  end

  // ----------------------------------------
  // Shift only while latch is low
  // ----------------------------------------
  always_ff @(posedge ser_clk) begin
    if (!serial_latch_enable) begin
      shift_r <= shift_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  assign lnk.shift_word = shift_r;
  assign lnk.bit_cnt    = cnt_r;

endmodule
`default_nettype wire

// [design/pdcw_refdet.sv]
// Reference frequency detector
`timescale 1ns/1ps
`default_nettype none
`include "pdcw_consts.svh"
module pdcw_refdet #(
  parameter int TIMEOUT_CYC = `PDCW_REF_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Reference pin
  input  wire logic ref_clk_in,
  // Result
  output logic      ref_valid
);

  logic                       s1_r;
  logic                       s2_r;
  logic                       s3_r;
  logic [`PDCW_REF_CNT_W-1:0] cnt_r;
  logic [`PDCW_REF_CNT_W-1:0] cnt_nxt;
  logic                       valid_r;
  logic                       valid_nxt;

  // ----------------------------------------
  // Period watchdog
  // ----------------------------------------
  always_comb begin
    cnt_nxt   = cnt_r;
    valid_nxt = valid_r;
    if (s2_r && !s3_r) begin
      cnt_nxt   = '0;
      valid_nxt = 1'b1;
    end else if (cnt_r >= TIMEOUT_CYC[`PDCW_REF_CNT_W-1:0]) begin
      valid_nxt = 1'b0;
    end else begin
      cnt_nxt = cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      cnt_r   <= '0;
      valid_r <= 1'b0;
    end else begin
      s1_r    <= ref_clk_in;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      cnt_r   <= cnt_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign ref_valid = valid_r;

endmodule
`default_nettype wire

// [design/pdcw_top.sv]
// Divider configuration word: serial capture and field outputs
`timescale 1ns/1ps
`default_nettype none
`include "pdcw_consts.svh"
module pdcw_top #(
  parameter int REF_TIMEOUT_CYC = `PDCW_REF_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Serial link
  input  wire logic        ser_clk,
  input  wire logic        ser_data,
  input  wire logic        serial_latch_enable,
  // Power and reference
  input  wire logic        power_down_n,
  input  wire logic        ref_clk_in,
  // Configuration fields
  output logic [9:0]       ref_predivider_field,
  output logic [11:0]      feedback_divider_field,
  output logic [2:0]       ref_phase_delay_field,
  output logic [2:0]       feedback_phase_delay_field,
  output logic             ref_select_auto,
  output logic             ref_freq_detect_disable,
  // Status
  output logic             status_ref,
  output logic             config_update,
  output logic             frame_len_error,
  output logic [1:0]       last_word_select
);

  localparam int NSYNC = 2;

  // ----------------------------------------
  // Word decode
  // ----------------------------------------
  function automatic pdcw_pkg::pdcw_cfg_t word_to_cfg(input logic [`PDCW_WORD_W-1:0] w);
    pdcw_pkg::pdcw_cfg_t c;
    c.ref_prediv     = w[`PDCW_PREDIV_LSB +: `PDCW_PREDIV_W];
    c.fb_div         = w[`PDCW_FBDIV_LSB +: `PDCW_FBDIV_W];
    c.ref_delay      = w[`PDCW_REFDLY_LSB +: `PDCW_DLY_W];
    c.fb_delay       = w[`PDCW_FBDLY_LSB +: `PDCW_DLY_W];
    c.select_auto    = w[`PDCW_AUTO_BIT];
    c.detect_disable = w[`PDCW_DETDIS_BIT];
    return c;
  endfunction

  function automatic logic [`PDCW_WORD_W-1:0] default_word();
    logic [`PDCW_WORD_W-1:0] w;
    w = '0;
    w[`PDCW_PREDIV_LSB +: `PDCW_PREDIV_W] = `PDCW_PREDIV_RST;
    w[`PDCW_FBDIV_LSB +: `PDCW_FBDIV_W]   = `PDCW_FBDIV_RST;
    w[`PDCW_REFDLY_LSB +: `PDCW_DLY_W]    = `PDCW_DLY_RST;
    w[`PDCW_FBDLY_LSB +: `PDCW_DLY_W]     = `PDCW_DLY_RST;
    w[`PDCW_AUTO_BIT]                     = `PDCW_AUTO_RST;
    w[`PDCW_DETDIS_BIT]                   = `PDCW_DETDIS_RST;
    return w;
  endfunction

  // ----------------------------------------
  // Link side
  // ----------------------------------------
  pdcw_link_if lnk ();

  pdcw_shifter u_shifter (
    .ser_clk             (ser_clk),
    .serial_latch_enable (serial_latch_enable),
    .ser_data            (ser_data),
    .lnk                 (lnk)
  );

  // ----------------------------------------
  // Reference detector
  // ----------------------------------------
  logic ref_valid;

  pdcw_refdet #(
    .TIMEOUT_CYC (REF_TIMEOUT_CYC)
  ) u_refdet (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .ref_clk_in (ref_clk_in),
    .ref_valid  (ref_valid)
  );

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [NSYNC-1:0] pin_in;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;

  assign pin_in = {serial_latch_enable, power_down_n};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          sync1_r[gi] <= 1'b1;
          sync2_r[gi] <= 1'b1;
        end else begin
          sync1_r[gi] <= pin_in[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  logic le_s;
  logic pd_n_s;

  assign le_s   = sync2_r[1];
  assign pd_n_s = sync2_r[0];

  // ----------------------------------------
  // Frame state and configuration
  // ----------------------------------------
  pdcw_pkg::pdcw_state_t state_r;
  pdcw_pkg::pdcw_state_t state_nxt;
  pdcw_pkg::pdcw_cfg_t   cfg_r;
  pdcw_pkg::pdcw_cfg_t   cfg_nxt;
  logic                  status_r;
  logic                  status_nxt;
  logic                  update_r;
  logic                  update_nxt;
  logic                  err_r;
  logic                  err_nxt;
  logic [1:0]            sel_r;
  logic [1:0]            sel_nxt;
  logic [1:0]            word_sel;
  logic                  len_ok;

  assign word_sel = lnk.shift_word[`PDCW_SEL_LSB +: `PDCW_SEL_W];
  assign len_ok   = (lnk.bit_cnt == `PDCW_CNT_FULL);

  always_comb begin
    state_nxt  = state_r;
    cfg_nxt    = cfg_r;
    update_nxt = 1'b0;
    err_nxt    = err_r;
    sel_nxt    = sel_r;
    unique case (state_r)
      pdcw_pkg::PDCW_ST_IDLE: begin
        if (!le_s) begin
          state_nxt = pdcw_pkg::PDCW_ST_FRAME;
        end
      end
      pdcw_pkg::PDCW_ST_FRAME: begin
        if (le_s) begin
          state_nxt = pdcw_pkg::PDCW_ST_LOAD;
        end
      end
      pdcw_pkg::PDCW_ST_LOAD: begin
        state_nxt = pdcw_pkg::PDCW_ST_IDLE;
        if (len_ok) begin
          err_nxt = 1'b0;
          sel_nxt = word_sel;
          if (word_sel == `PDCW_SEL_THIS) begin
            cfg_nxt    = word_to_cfg(lnk.shift_word);
            update_nxt = 1'b1;
          end
        end else begin
          err_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = pdcw_pkg::PDCW_ST_IDLE;
      end
    endcase
    if (!pd_n_s) begin
      state_nxt  = pdcw_pkg::PDCW_ST_IDLE;
      cfg_nxt    = word_to_cfg(default_word());
      update_nxt = 1'b0;
    end
  end

  // Reference status
  always_comb begin
    if (!pd_n_s) begin
      status_nxt = 1'b0;
    end else if (cfg_r.detect_disable) begin
      status_nxt = 1'b1;
    end else begin
      status_nxt = ref_valid;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r  <= pdcw_pkg::PDCW_ST_IDLE;
      cfg_r    <= word_to_cfg(default_word());
      status_r <= 1'b0;
      update_r <= 1'b0;
      err_r    <= 1'b0;
      sel_r    <= 2'h0;
    end else begin
      state_r  <= state_nxt;
      cfg_r    <= cfg_nxt;
      status_r <= status_nxt;
      update_r <= update_nxt;
      err_r    <= err_nxt;
      sel_r    <= sel_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign ref_predivider_field       = cfg_r.ref_prediv;
  assign feedback_divider_field     = cfg_r.fb_div;
  assign ref_phase_delay_field      = cfg_r.ref_delay;
  assign feedback_phase_delay_field = cfg_r.fb_delay;
  assign ref_select_auto            = cfg_r.select_auto;
  assign ref_freq_detect_disable    = cfg_r.detect_disable;
  assign status_ref                 = status_r;
  assign config_update              = update_r;
  assign frame_len_error            = err_r;
  assign last_word_select           = sel_r;

endmodule
`default_nettype wire

// [testbench/pdcw_monitor.sv]
// Checker of the divider configuration word block
`timescale 1ns/1ps
`default_nettype none
module pdcw_monitor #(
  parameter int REF_TIMEOUT_CYC = 50
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Pins
  input  wire logic        serial_latch_enable,
  input  wire logic        power_down_n,
  input  wire logic        ref_clk_in,
  // Fields and status
  input  wire logic [9:0]  ref_predivider_field,
  input  wire logic [11:0] feedback_divider_field,
  input  wire logic [2:0]  ref_phase_delay_field,
  input  wire logic [2:0]  feedback_phase_delay_field,
  input  wire logic        ref_select_auto,
  input  wire logic        ref_freq_detect_disable,
  input  wire logic        status_ref,
  input  wire logic        config_update,
  input  wire logic        frame_len_error,
  input  wire logic [1:0]  last_word_select
);
  logic [29:0] flds;
  logic        ref_prev_r;
  logic        ref_prev_nxt;
  int          quiet_r;
  int          quiet_nxt;

  assign flds = {ref_freq_detect_disable, ref_select_auto, feedback_phase_delay_field,
                 ref_phase_delay_field, feedback_divider_field, ref_predivider_field};

  // ------------------------------------------
  // Cycles since the reference pin moved
  // ------------------------------------------
  always_comb begin
    ref_prev_nxt = ref_clk_in;
    quiet_nxt    = (quiet_r < 1000) ? quiet_r + 1 : quiet_r;
    if (sys_rst || ref_clk_in != ref_prev_r) begin
      quiet_nxt = 0;
    end
  end

  always_ff @(posedge clk) begin
    ref_prev_r <= ref_prev_nxt;
    quiet_r    <= quiet_nxt;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_fields_atomic: assert property (
    $changed(flds) |-> config_update || !$past(power_down_n, 2)
      || !$past(power_down_n, 3) || !$past(power_down_n, 4))
    else $error("fields moved without update");
  a_update_pulse: assert property (
    config_update |=> !config_update)
    else $error("update pulse too long");
  a_update_word: assert property (
    config_update |-> last_word_select == 2'h0 && !frame_len_error)
    else $error("update from refused frame");
  a_update_latch: assert property (
    config_update |-> $past(serial_latch_enable, 1) && $past(serial_latch_enable, 2)
      && $past(serial_latch_enable, 3))
    else $error("update without latch rise");
  a_detect_off: assert property (
    (power_down_n && ref_freq_detect_disable) [*5] |-> status_ref)
    else $error("status low with detection off");
  a_ref_lost: assert property (
    quiet_r > REF_TIMEOUT_CYC + 6 && !ref_freq_detect_disable
      && !$past(ref_freq_detect_disable) |-> !status_ref)
    else $error("status high without reference");
  a_ref_seen: assert property (
    $rose(ref_clk_in) && !ref_freq_detect_disable |-> ##[1:6] (status_ref || !power_down_n))
    else $error("status low with reference");
  a_pd_defaults: assert property (
    !power_down_n [*4] |-> flds == 30'h0001_fc7f && !status_ref)
    else $error("power down values wrong");
endmodule

bind pdcw_top pdcw_monitor #(.REF_TIMEOUT_CYC(REF_TIMEOUT_CYC)) mon_u (
  .clk(clk), .sys_rst(sys_rst), .serial_latch_enable(serial_latch_enable),
  .power_down_n(power_down_n), .ref_clk_in(ref_clk_in),
  .ref_predivider_field(ref_predivider_field), .feedback_divider_field(feedback_divider_field),
  .ref_phase_delay_field(ref_phase_delay_field), .ref_select_auto(ref_select_auto),
  .feedback_phase_delay_field(feedback_phase_delay_field), .status_ref(status_ref),
  .ref_freq_detect_disable(ref_freq_detect_disable), .config_update(config_update),
  .frame_len_error(frame_len_error), .last_word_select(last_word_select)
);
`default_nettype wire

// [testbench/pdcw_host_model.sv]
// Host model driving the three-wire link
`timescale 1ns/1ps
`default_nettype none
module pdcw_host_model (
  // Link pins
  output logic ser_clk,
  output logic ser_data,
  output logic serial_latch_enable
);
  // Latch rises after time zero so the shifter's start flag sees an edge
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    serial_latch_enable = 1'b0;
    #1 serial_latch_enable = 1'b1;
  end


  // Shifts n bits MSB first; link clock still outside frames
  task automatic send(input logic [31:0] w, input int n);
    #7 serial_latch_enable = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      ser_data = w[i % 32];
      #15 ser_clk = 1'b1;
      #15 ser_clk = 1'b0;
    end
    #15 serial_latch_enable = 1'b1;
    ser_data = ~ser_data;
  endtask
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// Testbench of the divider configuration word block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) check_v(n, 32'(e), 32'(s))
module testbench;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        power_down_n = 1'b1;
  logic        ref_clk_in = 1'b0;
  logic        ref_run = 1'b1;
  logic        ser_clk;
  logic        ser_data;
  logic        serial_latch_enable;
  logic [9:0]  prediv;
  logic [11:0] fbdiv;
  logic [2:0]  refdly;
  logic [2:0]  fbdly;
  logic        auto_sel;
  logic        det_dis;
  logic        status_ref;
  logic        config_update;
  logic        frame_len_error;
  logic [1:0]  last_word_select;
  logic [29:0] flds;
  logic [29:0] cur = 30'h0001_fc7f;
  int          n_mismatch = 0;
  int          checked = 0;
  int          cyc = 0;

  assign flds = {det_dis, auto_sel, fbdly, refdly, fbdiv, prediv};

  pdcw_host_model host_u (.ser_clk(ser_clk), .ser_data(ser_data),
    .serial_latch_enable(serial_latch_enable));

  pdcw_top #(.REF_TIMEOUT_CYC(10)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .ser_clk(ser_clk), .ser_data(ser_data),
    .serial_latch_enable(serial_latch_enable), .power_down_n(power_down_n),
    .ref_clk_in(ref_clk_in), .ref_predivider_field(prediv), .feedback_divider_field(fbdiv),
    .ref_phase_delay_field(refdly), .feedback_phase_delay_field(fbdly),
    .ref_select_auto(auto_sel), .ref_freq_detect_disable(det_dis), .status_ref(status_ref),
    .config_update(config_update), .frame_len_error(frame_len_error),
    .last_word_select(last_word_select));

  always #5 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (ref_run) begin
      ref_clk_in <= ~ref_clk_in;
    end
    if (cyc == 6000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic check_v(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %0h seen %0h", n, e, s);
    end
  endtask

  // Sends one frame, counts update pulses, checks the outcome
  task automatic wr(input logic [31:0] w, input int n);
    int pulses;
    pulses = 0;
    host_u.send(w, n);
    repeat (12) begin
      @(posedge clk);
      if (config_update === 1'b1) pulses++;
    end
    if (n == 32 && w[1:0] == 2'h0) cur = w[31:2];
    `CHK("pulses", n == 32 && w[1:0] == 2'h0, pulses);
    `CHK("fields", cur, flds);
    `CHK("length error", n != 32, frame_len_error);
    if (n == 32) `CHK("select", w[1:0], last_word_select);
  endtask

  task automatic report_and_stop();
    if (n_mismatch == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (20) @(posedge clk);
    `CHK("reset fields", 30'h0001_fc7f, flds);
    `CHK("status", 1'b1, status_ref);
    wr(32'hffff_fffc, 32);
    wr(32'h5555_5554, 32);
    wr(32'haaaa_aaa8, 32);
    for (int s = 1; s < 4; s++) begin
      wr(32'h8765_4320 | 32'(s), 32);
    end
    wr(32'h0000_0000, 31);
    wr(32'h0000_0000, 33);
    wr(32'hc123_4564, 32);
    ref_run <= 1'b0;
    repeat (40) @(posedge clk);
    `CHK("status detect off", 1'b1, status_ref);
    wr(32'h4123_4564, 32);
    `CHK("status no ref", 1'b0, status_ref);
    ref_run <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK("status ref back", 1'b1, status_ref);
    power_down_n <= 1'b0;
    repeat (6) @(posedge clk);
    cur = 30'h0001_fc7f;
    `CHK("pd fields", cur, flds);
    power_down_n <= 1'b1;
    repeat (6) @(posedge clk);
    wr(32'h1234_5678, 32);
    report_and_stop();
  end
endmodule
`default_nettype wire
